// [core/lvdt_map.svh]
`ifndef LVDT_MAP_SVH
`define LVDT_MAP_SVH

// Object indices for channel 0; channel 1 adds the stride, except the command object, which has a single copy
`define IDX_LUT_CFG 16'h8001
`define IDX_SCALER 16'h8005
`define IDX_TRIM 16'h800E
`define IDX_COMP 16'h800F
`define IDX_FLAGS 16'h6000
`define IDX_CMD 16'hFB00
`define CH_STRIDE 16'h0010
`define CH_BIT 4

// Subindices
`define SUB_COUNT 8'h00
`define SUB_FIRST 8'h01
`define SUB_LUT_LEN 8'h21
`define SUB_CMD_REQ 8'h01
`define SUB_CMD_STATUS 8'h02
`define SUB_CMD_RESP 8'h03
`define SUB_BELOW 8'h01
`define SUB_ABOVE 8'h02
`define SUB_EXC_FAULT 8'h03
`define SUB_SEC_FAULT 8'h04
`define SUB_DIN 8'h08
`define SUB_CAP_VALID 8'h0A
`define SUB_PRESET_DONE 8'h0B
`define SUB_NEW_MSG 8'h0D
`define SUB_INVALID 8'h0E
`define SUB_SEQ 8'h0F

// Entry counts read at subindex 0
`define SCALER_COUNT 8'h28
`define TRIM_COUNT 8'h14
`define COMP_COUNT 8'h40
`define CMD_COUNT 8'h03
`define FLAGS_COUNT 8'h0F

// Command codes and status values
`define CMD_CLR_BOTH 16'h8010
`define CMD_CLR_CH0 16'h8011
`define CMD_CLR_CH1 16'h8012
`define CMD_ST_BUSY 8'hFF
`define CMD_ST_OK 8'h00
`define CMD_ST_FAIL 8'h01

// Reset values
`define LUT_LEN_RST 8'h0A
`define WORD_ZERO 32'h0000_0000
`define VENDOR_WORD 32'h0000_0000

`endif

// [core/lvdt_pkg.sv]
package lvdt_pkg;

	typedef struct packed {
		logic req;
		logic wr;
		logic [15:0] index;
		logic [7:0] sub;
		logic [31:0] wdata;
	} obj_req_t;

	typedef struct packed {
		logic ack;
		logic err;
		logic [31:0] rdata;
	} obj_rsp_t;

	// Measurement-side inputs of one channel
	typedef struct packed {
		logic below;
		logic above;
		logic exc_fault;
		logic sec_fault;
		logic din;
		logic invalid;
		logic capture;
		logic latch_en;
		logic preset_loaded;
		logic set_pos_req;
		logic msg_entered;
		logic msg_ack;
		logic new_data;
	} ch_in_t;

	typedef struct packed {
		logic below;
		logic above;
		logic exc_fault;
		logic sec_fault;
		logic din;
		logic cap_valid;
		logic preset_done;
		logic new_msg;
		logic invalid;
		logic [1:0] seq;
	} ch_flags_t;

	typedef enum logic [2:0] {
		ACC_IDLE = 3'b001,
		ACC_FETCH = 3'b010,
		ACC_REPLY = 3'b100
	} acc_st_t;

	typedef enum logic [1:0] {
		CMD_IDLE = 2'b01,
		CMD_BUSY = 2'b10
	} cmd_st_t;

	typedef struct packed {
		acc_st_t acc;
		cmd_st_t cmd;
		logic [15:0] cmd_req;
		logic [7:0] cmd_status;
		logic [31:0] cmd_resp;
		logic [1:0] clr;
		logic [1:0][7:0] lut_len;
		ch_flags_t [1:0] flags;
		logic [31:0] rdata;
		logic err;
		logic from_mem;
	} st_t;

endpackage

// [core/lvdt_table_mem.sv]
`timescale 1ns/10ps
`include "lvdt_map.svh"
module lvdt_table_mem #(
	parameter int W = 32,
	parameter int AW = 7
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_we,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [W-1:0] i_wdata,
	input wire logic [AW-1:0] i_raddr,
	output logic [W-1:0] o_rdata
);
	logic [W-1:0] mem_r [0:(1<<AW)-1];
	// Entries never written read as zero, so no clearing pass is needed
	logic [(1<<AW)-1:0] written_r;

	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem_r[i_waddr] <= i_wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			written_r <= '0;
			o_rdata <= '0;
		end else begin
			if (i_we) begin
				written_r[i_waddr] <= 1'b1;
			end
			o_rdata <= written_r[i_raddr] ? mem_r[i_raddr] : W'(`WORD_ZERO);
		end
	end
endmodule

// [core/lvdt_channel_status_command.sv]
`timescale 1ns/10ps
`include "lvdt_map.svh"
// What this block does
// - Each channel holds forty writable signed words: x values odd, y values even.
// - Request 0x8010 clears both offsets, 0x8011 channel one, 0x8012 channel two.
// - Command status reads 255 while executing, completion code when finished.
// - A read-only four-byte response holds the command's optional result.
// - Underrange flag follows the measurement being below range.
// - Overrange flag follows the measurement being above range.
// - Excitation fault flag shows primary short or excitation overload.
// - Input fault flag shows secondary wire break or amplitude error.
// - A status bit mirrors the digital input level.
// - Latch-valid bit is set when the digital input captures the position.
// - Preset-done bit set after a load; cleared once the set-position request returns to 0.
// - Diagnosis bit is set when a new history message is entered.
// - Validity bit reads 0 for valid input data, 1 for invalid.
// - A 2-bit cycle counter advances only on a new input data set.
// - Two read-only vendor areas per channel, 20 and 64 entries.
// - Used lookup entries follow a length setting up to forty, default ten.
module lvdt_channel_status_command
	import lvdt_pkg::*;
#(
	parameter int LUT_MAX = 40,
	parameter logic [7:0] LUT_LEN_DEFAULT = `LUT_LEN_RST
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire obj_req_t i_obj,
	output logic o_ready,
	output obj_rsp_t o_obj,
	input wire ch_in_t [1:0] i_ch,
	output ch_flags_t [1:0] o_flags,
	output logic [1:0][7:0] o_lut_len,
	output logic [1:0] o_clear_offset,
	input wire logic i_offset_cleared
);
	localparam int AW = 7;

	initial begin
		if (LUT_MAX < 1 || LUT_MAX > 64 || LUT_MAX > int'(`SCALER_COUNT)) begin
			$error("LUT_MAX out of range");
		end
		if (int'(LUT_LEN_DEFAULT) > LUT_MAX) begin
			$error("LUT_LEN_DEFAULT above LUT_MAX");
		end
	end

	st_t st_r;
	st_t st_nxt;

	logic mem_we;
	logic [AW-1:0] mem_waddr;
	logic [AW-1:0] mem_raddr;
	logic [31:0] mem_rdata;

	// True when the index addresses one of the two channel copies of an object
	function automatic logic is_ch_obj(input logic [15:0] idx, input logic [15:0] base);
		is_ch_obj = (idx == base) || (idx == 16'(base + `CH_STRIDE));
	endfunction

	function automatic logic ch_of(input logic [15:0] idx);
		ch_of = idx[`CH_BIT];
	endfunction

	// Subindex inside 1..limit
	function automatic logic sub_in(input logic [7:0] sub, input logic [7:0] limit);
		sub_in = (sub >= `SUB_FIRST) && (sub <= limit);
	endfunction

	function automatic logic [AW-1:0] tbl_addr(input logic [15:0] idx, input logic [7:0] sub);
		logic [7:0] ofs;
		ofs = 8'(sub - `SUB_FIRST);
		tbl_addr = {ch_of(idx), ofs[AW-2:0]};
	endfunction

	lvdt_table_mem #(
		.W(32),
		.AW(AW)
	) u_table (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_we(mem_we),
		.i_waddr(mem_waddr),
		.i_wdata(i_obj.wdata),
		.i_raddr(mem_raddr),
		.o_rdata(mem_rdata)
	);

	assign o_ready = (st_r.acc == ACC_IDLE);
	assign o_obj.ack = (st_r.acc == ACC_REPLY);
	assign o_obj.err = st_r.err;
	assign o_obj.rdata = st_r.rdata;
	assign o_flags = st_r.flags;
	assign o_lut_len = st_r.lut_len;
	assign o_clear_offset = st_r.clr;

	assign mem_waddr = tbl_addr(i_obj.index, i_obj.sub);
	assign mem_raddr = tbl_addr(i_obj.index, i_obj.sub);

	always_comb begin
		logic take;
		logic ch;
		logic tbl_hit;
		ch_flags_t f;
		take = i_obj.req && (st_r.acc == ACC_IDLE);
		ch = ch_of(i_obj.index);
		tbl_hit = is_ch_obj(i_obj.index, `IDX_SCALER) && sub_in(i_obj.sub, `SCALER_COUNT);
		f = '0;
		st_nxt = st_r;
		mem_we = 1'b0;

		// Flag word, refreshed every cycle for both channels
		for (int n = 0; n < 2; n++) begin
			st_nxt.flags[n].below = i_ch[n].below;
			st_nxt.flags[n].above = i_ch[n].above;
			st_nxt.flags[n].exc_fault = i_ch[n].exc_fault;
			st_nxt.flags[n].sec_fault = i_ch[n].sec_fault;
			st_nxt.flags[n].din = i_ch[n].din;
			st_nxt.flags[n].invalid = i_ch[n].invalid;
			// Only a low enable re-arms; a capture while valid is ignored
			if (!i_ch[n].latch_en) begin
				st_nxt.flags[n].cap_valid = 1'b0;
			end else if (i_ch[n].capture) begin
				st_nxt.flags[n].cap_valid = 1'b1;
			end
			// Set wins over the clear in the same cycle
			if (i_ch[n].preset_loaded) begin
				st_nxt.flags[n].preset_done = 1'b1;
			end else if (!i_ch[n].set_pos_req) begin
				st_nxt.flags[n].preset_done = 1'b0;
			end
			if (i_ch[n].msg_entered) begin
				st_nxt.flags[n].new_msg = 1'b1;
			end else if (i_ch[n].msg_ack) begin
				st_nxt.flags[n].new_msg = 1'b0;
			end
			if (i_ch[n].new_data) begin
				st_nxt.flags[n].seq = 2'(st_r.flags[n].seq + 2'h1);
			end
		end

		// Command execution: waits for the offset logic to confirm
		case (st_r.cmd)
			CMD_IDLE: begin
				st_nxt.clr = 2'b00;
			end
			CMD_BUSY: begin
				if (i_offset_cleared) begin
					st_nxt.cmd_resp = {30'h0000_0000, st_r.clr};
					st_nxt.clr = 2'b00;
					st_nxt.cmd_status = `CMD_ST_OK;
					st_nxt.cmd = CMD_IDLE;
				end
			end
			default: begin
				st_nxt.cmd = CMD_IDLE;
				st_nxt.clr = 2'b00;
			end
		endcase

		// Object access
		case (st_r.acc)
			ACC_IDLE: begin
				if (take) begin
					st_nxt.acc = ACC_FETCH;
					st_nxt.err = 1'b0;
					st_nxt.from_mem = 1'b0;
					st_nxt.rdata = `WORD_ZERO;
					if (is_ch_obj(i_obj.index, `IDX_SCALER)) begin
						if (i_obj.sub == `SUB_COUNT) begin
							if (i_obj.wr) begin
								st_nxt.err = 1'b1;
							end else begin
								st_nxt.rdata = {24'h00_0000, `SCALER_COUNT};
							end
						end else if (tbl_hit) begin
							// Odd subindex is x, even is y
							mem_we = i_obj.wr;
							st_nxt.from_mem = !i_obj.wr;
						end else begin
							st_nxt.err = 1'b1;
						end
					end else if (is_ch_obj(i_obj.index, `IDX_LUT_CFG) &&
							i_obj.sub == `SUB_LUT_LEN) begin
						if (i_obj.wr) begin
							if (i_obj.wdata > 32'(LUT_MAX)) begin
								st_nxt.err = 1'b1;
							end else begin
								st_nxt.lut_len[ch] = i_obj.wdata[7:0];
							end
						end else begin
							st_nxt.rdata = {24'h00_0000, st_r.lut_len[ch]};
						end
					end else if (is_ch_obj(i_obj.index, `IDX_TRIM) ||
							is_ch_obj(i_obj.index, `IDX_COMP)) begin
						// Factory data: never writable from the bus
						if (i_obj.wr) begin
							st_nxt.err = 1'b1;
						end else if (i_obj.sub == `SUB_COUNT) begin
							st_nxt.rdata = is_ch_obj(i_obj.index, `IDX_TRIM) ?
								{24'h00_0000, `TRIM_COUNT} :
								{24'h00_0000, `COMP_COUNT};
						end else if (is_ch_obj(i_obj.index, `IDX_TRIM) ?
								sub_in(i_obj.sub, `TRIM_COUNT) :
								sub_in(i_obj.sub, `COMP_COUNT)) begin
							st_nxt.rdata = `VENDOR_WORD;
						end else begin
							st_nxt.err = 1'b1;
						end
					end else if (i_obj.index == `IDX_CMD) begin
						case (i_obj.sub)
							`SUB_COUNT: begin
								st_nxt.err = i_obj.wr;
								st_nxt.rdata = {24'h00_0000, `CMD_COUNT};
							end
							`SUB_CMD_REQ: begin
								if (!i_obj.wr) begin
									st_nxt.rdata = {16'h0000, st_r.cmd_req};
								end else if (st_r.cmd == CMD_BUSY) begin
									// A new command would lose the pending one
									st_nxt.err = 1'b1;
								end else begin
									st_nxt.cmd_req = i_obj.wdata[15:0];
									st_nxt.cmd_resp = `WORD_ZERO;
									st_nxt.cmd_status = `CMD_ST_BUSY;
									st_nxt.cmd = CMD_BUSY;
									case (i_obj.wdata[15:0])
										`CMD_CLR_BOTH: st_nxt.clr = 2'b11;
										`CMD_CLR_CH0: st_nxt.clr = 2'b01;
										`CMD_CLR_CH1: st_nxt.clr = 2'b10;
										default: begin
											st_nxt.cmd_status = `CMD_ST_FAIL;
											st_nxt.cmd = CMD_IDLE;
										end
									endcase
								end
							end
							`SUB_CMD_STATUS: begin
								st_nxt.err = i_obj.wr;
								st_nxt.rdata = {24'h00_0000, st_r.cmd_status};
							end
							`SUB_CMD_RESP: begin
								st_nxt.err = i_obj.wr;
								st_nxt.rdata = st_r.cmd_resp;
							end
							default: begin
								st_nxt.err = 1'b1;
							end
						endcase
					end else if (is_ch_obj(i_obj.index, `IDX_FLAGS)) begin
						f = st_r.flags[ch];
						st_nxt.err = i_obj.wr;
						case (i_obj.sub)
							`SUB_COUNT: st_nxt.rdata = {24'h00_0000, `FLAGS_COUNT};
							`SUB_BELOW: st_nxt.rdata = {31'h0000_0000, f.below};
							`SUB_ABOVE: st_nxt.rdata = {31'h0000_0000, f.above};
							`SUB_EXC_FAULT: st_nxt.rdata = {31'h0000_0000, f.exc_fault};
							`SUB_SEC_FAULT: st_nxt.rdata = {31'h0000_0000, f.sec_fault};
							`SUB_DIN: st_nxt.rdata = {31'h0000_0000, f.din};
							`SUB_CAP_VALID: st_nxt.rdata = {31'h0000_0000, f.cap_valid};
							`SUB_PRESET_DONE: st_nxt.rdata = {31'h0000_0000, f.preset_done};
							`SUB_NEW_MSG: st_nxt.rdata = {31'h0000_0000, f.new_msg};
							`SUB_INVALID: st_nxt.rdata = {31'h0000_0000, f.invalid};
							`SUB_SEQ: st_nxt.rdata = {30'h0000_0000, f.seq};
							default: begin
								st_nxt.err = 1'b1;
							end
						endcase
					end else begin
						st_nxt.err = 1'b1;
					end
				end
			end
			ACC_FETCH: begin
				if (st_r.from_mem) begin
					st_nxt.rdata = mem_rdata;
				end
				st_nxt.acc = ACC_REPLY;
			end
			ACC_REPLY: begin
				st_nxt.acc = ACC_IDLE;
			end
			default: begin
				st_nxt.acc = ACC_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r.acc <= ACC_IDLE;
			st_r.cmd <= CMD_IDLE;
			st_r.cmd_req <= 16'h0000;
			st_r.cmd_status <= `CMD_ST_OK;
			st_r.cmd_resp <= `WORD_ZERO;
			st_r.clr <= 2'b00;
			st_r.lut_len <= {LUT_LEN_DEFAULT, LUT_LEN_DEFAULT};
			st_r.flags <= '0;
			st_r.rdata <= `WORD_ZERO;
			st_r.err <= 1'b0;
			st_r.from_mem <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule

// [testbench/lvdt_channel_status_command_assertions.sv]
`timescale 1ns/10ps
`include "lvdt_map.svh"
module lvdt_channel_status_command_assertions
	import lvdt_pkg::*;
#(
	parameter int LUT_MAX = 40
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire obj_req_t i_obj,
	input wire logic o_ready,
	input wire obj_rsp_t o_obj,
	input wire ch_in_t [1:0] i_ch,
	input wire ch_flags_t [1:0] o_flags,
	input wire logic [1:0][7:0] o_lut_len,
	input wire logic [1:0] o_clear_offset,
	input wire logic i_offset_cleared
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);
	logic take;
	logic cmd_wr;
	logic [15:0] code;
	logic [1:0] mask;
	assign take = i_obj.req && o_ready;
	assign cmd_wr = take && i_obj.wr && i_obj.index == `IDX_CMD && i_obj.sub == `SUB_CMD_REQ;
	assign code = i_obj.wdata[15:0];
	assign mask = code == `CMD_CLR_BOTH ? 2'h3 : code == `CMD_CLR_CH0 ? 2'h1 :
		code == `CMD_CLR_CH1 ? 2'h2 : 2'h0;
	a_answer_timing: assert property (
		take |=> !o_ready ##1 (o_obj.ack && !o_ready) ##1 o_ready) else $error("late answer");
	a_vendor_ro: assert property (
		take && i_obj.wr && i_obj.index inside {16'h800E, 16'h800F, 16'h801E, 16'h801F}
		|-> ##2 o_obj.ack && o_obj.err) else $error("vendor area written");
	a_len_limit: assert property (
		take && i_obj.wr && i_obj.index inside {16'h8001, 16'h8011} && i_obj.sub == 8'h21
		&& i_obj.wdata[7:0] > LUT_MAX |-> ##2 o_obj.ack && o_obj.err) else $error("length taken");
	a_cmd_start: assert property (
		cmd_wr && o_clear_offset == 2'h0 |=> o_clear_offset == $past(mask))
		else $error("wrong clear mask");
	a_cmd_end: assert property (
		o_clear_offset != 2'h0 && i_offset_cleared |=> o_clear_offset == 2'h0)
		else $error("command not finished");
	a_level_follow: assert property (
		$past(i_rst_b) |-> {o_flags[1][10:6], o_flags[0][10:6], o_flags[0].invalid} ==
		$past({i_ch[1][12:8], i_ch[0][12:8], i_ch[0].invalid})) else $error("level flag lag");
	a_latch_set: assert property (
		i_ch[0].capture && i_ch[0].latch_en |=> o_flags[0].cap_valid) else $error("no latch");
	a_latch_rearm: assert property (
		!i_ch[0].latch_en |=> !o_flags[0].cap_valid) else $error("latch not cleared");
	a_preset_done: assert property (
		i_ch[0].preset_loaded |=> o_flags[0].preset_done) else $error("preset flag missing");
	a_diag_set: assert property (
		i_ch[0].msg_entered |=> o_flags[0].new_msg) else $error("diag flag missing");
	a_seq_step: assert property (
		$past(i_rst_b) |-> o_flags[0].seq == $past(o_flags[0].seq) + $past(i_ch[0].new_data))
		else $error("cycle counter step");
endmodule
bind lvdt_channel_status_command lvdt_channel_status_command_assertions #(
	.LUT_MAX(LUT_MAX)
) u_assert (
	.i_clk, .i_rst_b, .i_obj, .o_ready, .o_obj, .i_ch, .o_flags, .o_lut_len,
	.o_clear_offset, .i_offset_cleared
);

// [testbench/lvdt_master_model.sv]
`timescale 1ns/10ps
module lvdt_master_model
	import lvdt_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_ready,
	input wire obj_rsp_t i_rsp,
	output obj_req_t o_req
);
	initial o_req = '0;
	// Request held until taken or until ready has stayed low for 8 negedges; released lines show the inverse, not stale values
	task automatic access(input obj_req_t q, output obj_rsp_t r);
		int n;
		r = '0;
		n = 0;
		@(posedge i_clk);
		o_req <= q;
		@(negedge i_clk);
		while (i_ready !== 1'b1 && n < 8) begin
			@(negedge i_clk);
			n++;
		end
		@(posedge i_clk);
		o_req <= '{1'b0, ~q.wr, ~q.index, ~q.sub, ~q.wdata};
		for (n = 0; n < 4 && r.ack !== 1'b1; n++) begin
			@(negedge i_clk);
			r = i_rsp;
		end
	endtask
endmodule

// [testbench/lvdt_channel_status_command_tb.sv]
`timescale 1ns/10ps
`include "lvdt_map.svh"
module lvdt_channel_status_command_tb
	import lvdt_pkg::*;
;
	typedef struct packed {
		logic wr;
		logic [15:0] ix;
		logic [7:0] sb;
		logic [31:0] wd;
		logic er;
		logic [31:0] ex;
	} row_t;
	localparam row_t ROWS [18] = '{
		'{1'h0,16'hFB00,8'h02,32'h0,1'h0,32'h0}, '{1'h0,16'hFB00,8'h03,32'h0,1'h0,32'h0},
		'{1'h0,16'h6010,8'h0F,32'h0,1'h0,32'h0}, '{1'h0,16'h8005,8'h00,32'h0,1'h0,32'h28},
		'{1'h1,16'h8005,8'h01,32'h80000001,1'h0,32'h0},
		'{1'h1,16'h8015,8'h28,32'h7FFFFFFE,1'h0,32'h0},
		'{1'h0,16'h8005,8'h01,32'h0,1'h0,32'h80000001},
		'{1'h0,16'h8015,8'h28,32'h0,1'h0,32'h7FFFFFFE},
		'{1'h0,16'h8005,8'h29,32'h0,1'h1,32'h0}, '{1'h0,16'h800E,8'h00,32'h0,1'h0,32'h14},
		'{1'h0,16'h801F,8'h00,32'h0,1'h0,32'h40}, '{1'h1,16'h800E,8'h01,32'h5,1'h1,32'h0},
		'{1'h1,16'h8011,8'h21,32'h29,1'h1,32'h0}, '{1'h1,16'h8011,8'h21,32'h28,1'h0,32'h0},
		'{1'h0,16'hFB00,8'h00,32'h0,1'h0,32'h3}, '{1'h0,16'h6000,8'h00,32'h0,1'h0,32'hF},
		'{1'h1,16'h6000,8'h01,32'h1,1'h1,32'h0}, '{1'h0,16'h7000,8'h00,32'h0,1'h1,32'h0}
	};
	localparam logic [15:0] CODES [3] = '{`CMD_CLR_BOTH, `CMD_CLR_CH0, `CMD_CLR_CH1};
	localparam logic [1:0] MASKS [3] = '{2'h3, 2'h1, 2'h2};
	logic i_clk;
	logic i_rst_b;
	obj_req_t req;
	obj_rsp_t rsp;
	logic rdy;
	ch_in_t [1:0] ch;
	ch_flags_t [1:0] fl;
	logic [1:0][7:0] len;
	logic [1:0] clr;
	logic cleared;
	int n_errors;
	int n_compared;
	lvdt_channel_status_command DUT (
		.i_clk(i_clk), .i_rst_b(i_rst_b), .i_obj(req), .o_ready(rdy), .o_obj(rsp),
		.i_ch(ch), .o_flags(fl), .o_lut_len(len), .o_clear_offset(clr),
		.i_offset_cleared(cleared)
	);
	lvdt_master_model m (.i_clk(i_clk), .i_ready(rdy), .i_rsp(rsp), .o_req(req));
	task automatic chk(input logic ok, input string s);
		n_compared++;
		if (!ok) begin
			n_errors++;
			$display("MISMATCH t=%0t %s", $time, s);
		end
	endtask
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// A lost answer ends the run: later checks would only cascade
	task automatic acc(input row_t w);
		obj_rsp_t r;
		m.access('{1'b1, w.wr, w.ix, w.sb, w.wd}, r);
		chk(r.ack === 1'b1 && r.err === w.er && (w.wr || w.er || r.rdata === w.ex), "access");
		if (r.ack !== 1'b1) begin
			conclude();
		end
	endtask
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	initial begin
		i_rst_b = 1'b0;
		ch = '0;
		cleared = 1'b0;
		n_errors = 0;
		n_compared = 0;
		repeat (8) @(posedge i_clk);
		i_rst_b <= 1'b1;
		@(negedge i_clk) chk(fl === '0 && len === {2{`LUT_LEN_RST}} && clr === 2'h0, "rst");
		foreach (ROWS[i]) begin
			acc(ROWS[i]);
		end
		chk(len === {8'h28, `LUT_LEN_RST}, "lookup length");
		$display("test table done");
		for (int i = 0; i < 3; i++) begin
			acc('{1'h1, `IDX_CMD, 8'h01, {16'h0, CODES[i]}, 1'h0, 32'h0});
			chk(clr === MASKS[i], "clear mask");
			acc('{1'h0, `IDX_CMD, 8'h02, 32'h0, 1'h0, 32'hFF});
			acc('{1'h1, `IDX_CMD, 8'h01, {16'h0, CODES[i]}, 1'h1, 32'h0});
			@(posedge i_clk) cleared <= 1'b1;
			@(posedge i_clk) cleared <= 1'b0;
			acc('{1'h0, `IDX_CMD, 8'h02, 32'h0, 1'h0, 32'h0});
			acc('{1'h0, `IDX_CMD, 8'h03, 32'h0, 1'h0, {30'h0, MASKS[i]}});
			chk(clr === 2'h0, "clear end");
		end
		acc('{1'h1, `IDX_CMD, 8'h01, 32'h1234, 1'h0, 32'h0});
		acc('{1'h0, `IDX_CMD, 8'h02, 32'h0, 1'h0, 32'h1});
		$display("test command done");
		@(posedge i_clk) ch <= {ch_in_t'{above: 1, sec_fault: 1, default: 0},
			ch_in_t'{below: 1, exc_fault: 1, din: 1, invalid: 1, default: 0}};
		repeat (2) @(negedge i_clk);
		chk(fl === {ch_flags_t'{above: 1, sec_fault: 1, default: 0},
			ch_flags_t'{below: 1, exc_fault: 1, din: 1, invalid: 1, default: 0}}, "levels");
		acc('{1'h0, 16'h6000, `SUB_INVALID, 32'h0, 1'h0, 32'h1});
		@(posedge i_clk) ch <= '0;
		@(posedge i_clk) ch[0].capture <= 1'b1;
		@(posedge i_clk) ch[0] <= ch_in_t'{latch_en: 1, default: 0};
		@(negedge i_clk) chk(fl[0].cap_valid === 1'b0, "latch off");
		@(posedge i_clk) ch[0].capture <= 1'b1;
		@(posedge i_clk) ch[0].capture <= 1'b0;
		@(negedge i_clk) chk(fl[0].cap_valid === 1'b1, "latch set");
		@(posedge i_clk) ch[0].latch_en <= 1'b0;
		@(posedge i_clk) ch[0].latch_en <= 1'b1;
		@(negedge i_clk) chk(fl[0].cap_valid === 1'b0, "rearm");
		@(posedge i_clk) ch[0] <= ch_in_t'{set_pos_req: 1, preset_loaded: 1, msg_entered: 1,
			default: 0};
		@(posedge i_clk) ch[0] <= ch_in_t'{set_pos_req: 1, default: 0};
		@(negedge i_clk) chk(fl[0].preset_done === 1'b1 && fl[0].new_msg === 1'b1, "set");
		@(posedge i_clk) ch[0] <= ch_in_t'{msg_ack: 1, default: 0};
		@(posedge i_clk) ch[0] <= '0;
		@(negedge i_clk) chk(fl[0].preset_done === 1'b0 && fl[0].new_msg === 1'b0, "clr");
		for (int i = 0; i < 5; i++) begin
			@(posedge i_clk) ch[0].new_data <= 1'b1;
			@(posedge i_clk) ch[0].new_data <= 1'b0;
		end
		@(negedge i_clk) chk(fl[0].seq === 2'h1 && fl[1].seq === 2'h0, "counter");
		$display("test flags done");
		@(posedge i_clk) ch[0].below <= 1'b1;
		@(posedge i_clk) i_rst_b <= 1'b0;
		@(negedge i_clk) chk(fl === '0 && len === {2{`LUT_LEN_RST}} && rdy === 1'b1, "rst");
		@(posedge i_clk) i_rst_b <= 1'b1;
		acc('{1'h0, 16'h8011, 8'h21, 32'h0, 1'h0, 32'hA});
		$display("test reset done");
		conclude();
	end
endmodule
